// [core/ckg_config.v]
// Purpose: configuration fields and output control of clock generator
// Assumes: synth and reference clocks arrive as clk-rate tick pulses
// Notes: registers written over apb; analog parts are modelled as codes
//
// Design decisions made here: the register offsets and the APB slave port.
`include "ckg_defs.vh"
`default_nettype none
module ckg_config
#(
  parameter DIV_W = 7
)
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // pins
  input wire selectInputHigh,
  input wire serialClkPin,
  input wire serialDataPin,
  input wire shutdownPin,
  // source ticks: ref, synth one 0/180, two 0/180, three 0/180
  input wire refTick,
  input wire [1:0] synthOneTick,
  input wire [1:0] synthTwoTick,
  input wire [1:0] synthThreeTick,
  // clock outputs, oe low means driving
  output wire [3:0] outMain,
  output wire [3:0] outMainOe_n,
  output reg outputE,
  output wire outputEOe_n,
  output wire refBufOut,
  output wire refBufOe_n,
  // analog control codes
  output wire [10:0] synthOnePt,
  output wire [8:0] synthOneQt,
  output wire [2:0] synthOneLoop,
  output wire synthOneRun,
  output wire [10:0] synthTwoPt,
  output wire [8:0] synthTwoQt,
  output wire [2:0] synthTwoLoop,
  output wire synthTwoRun,
  output wire [10:0] synthThreePt,
  output wire [8:0] synthThreeQt,
  output wire [2:0] synthThreeLoop,
  output wire synthThreeRun,
  output wire [5:0] loadCapCode,
  output wire [1:0] oscGainCode,
  output wire [1:0] dutyTrimCX,
  output wire [1:0] dutyTrimABDE,
  output wire [7:0] driveTrim,
  output wire fullShutdown
);
  // ***************************************************
  // functions
  // ***************************************************
  // pt = 2*(p+3)+odd
  function [10:0] calcPt;
    input [9:0] p;
    input odd;
    begin
      calcPt = {p + 10'h003, odd};
    end
  endfunction
  // qt = q + 2
  function [8:0] calcQt;
    input [7:0] q;
    begin
      calcQt = {1'b0, q} + 9'h002;
    end
  endfunction
  // ***************************************************
  // register storage, all zero when blank
  // ***************************************************
  reg [7:0] divA0_r, divA1_r, divB0_r, divB1_r, divC_r, divD_r;
  reg [7:0] srcHi_r, misc_r, drv_r, osc_r;
  reg [7:0] twoQ_r, twoP_r, twoCtl_r, s3Q_r, s3P_r, s3Ctl_r;
  reg [7:0] s1Q_r [0:7];  // synth one table, indexed by row
  reg [7:0] s1P_r [0:7];
  reg [7:0] s1Ctl_r [0:7];
  reg [2:0] rowIdx_r;     // latched table index
  reg started_r;
  // ***************************************************
  // apb decode
  // ***************************************************
  wire [7:0] addr = paddr[7:0];
  wire wrEn = psel && penable && pwrite;
  wire s1Hit = (addr >= `CKG_S1_BASE) && (addr < `CKG_STATUS);
  // row number counts from the table base, not from address zero
  wire [7:0] s1Off = addr - `CKG_S1_BASE;
  wire [2:0] s1Row = s1Off[6:4];
  wire [1:0] s1Sel = addr[3:2];
  // zero-wait slave; unmapped reads zero, flagged as error
  wire mapped = (addr <= `CKG_OSC) || s1Hit || addr == `CKG_STATUS;
  assign pready = 1'b1;
  assign pslverr = psel && penable &&
                   (!mapped || paddr[11:8] != 4'h0 || addr[1:0] != 2'h0 ||
                    (s1Hit && s1Sel == 2'h3));
  integer i;
  // each byte written is stored at once, no shadowing; dividers pick up a new nonzero ratio at period end
  // serial side is clocked only by bus access, so stays live in
  // shutdown
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      divA0_r <= 8'h00; divA1_r <= 8'h00; divB0_r <= 8'h00;
      divB1_r <= 8'h00; divC_r <= 8'h00; divD_r <= 8'h00;
      srcHi_r <= 8'h00; misc_r <= 8'h00; drv_r <= 8'h00;
      osc_r <= 8'h00;
      twoQ_r <= 8'h00; twoP_r <= 8'h00; twoCtl_r <= 8'h00;
      s3Q_r <= 8'h00; s3P_r <= 8'h00; s3Ctl_r <= 8'h00;
      for (i = 0; i < 8; i = i + 1)
      begin
        s1Q_r[i] <= 8'h00;
        s1P_r[i] <= 8'h00;
        s1Ctl_r[i] <= 8'h00;
      end
    end
    else if (wrEn && !pslverr)
    begin
      case (addr)
        `CKG_A_DIV0: divA0_r <= pwdata[7:0];
        `CKG_A_DIV1: divA1_r <= pwdata[7:0];
        `CKG_B_DIV0: divB0_r <= pwdata[7:0];
        `CKG_B_DIV1: divB1_r <= pwdata[7:0];
        `CKG_C_DIV: divC_r <= pwdata[7:0];
        `CKG_D_DIV: divD_r <= pwdata[7:0];
        `CKG_SRC_HI: srcHi_r <= pwdata[7:0];
        `CKG_MISC: misc_r <= pwdata[7:0];
        `CKG_DRV: drv_r <= pwdata[7:0];
        `CKG_TWO_Q: twoQ_r <= pwdata[7:0];
        `CKG_TWO_P: twoP_r <= pwdata[7:0];
        `CKG_TWO_CTL: twoCtl_r <= pwdata[7:0];
        `CKG_S3_Q: s3Q_r <= pwdata[7:0];
        `CKG_S3_P: s3P_r <= pwdata[7:0];
        `CKG_S3_CTL: s3Ctl_r <= pwdata[7:0];
        `CKG_OSC: osc_r <= pwdata[7:0];
        default:
        begin
          // synth one table rows
          if (s1Hit && s1Sel == 2'h0)
            s1Q_r[s1Row] <= pwdata[7:0];
          else if (s1Hit && s1Sel == 2'h1)
            s1P_r[s1Row] <= pwdata[7:0];
          else if (s1Hit && s1Sel == 2'h2)
            s1Ctl_r[s1Row] <= pwdata[7:0];
        end
      endcase
    end
  end
  // ***************************************************
  // start-up latch of serial pin levels
  // ***************************************************
  // caught once after reset release; select input stays live
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      started_r <= 1'b0;
      rowIdx_r <= 3'h0;
    end
    else
    begin
      started_r <= 1'b1;
      if (!started_r)
        rowIdx_r[1:0] <= {serialClkPin, serialDataPin};
      else
        rowIdx_r[2] <= selectInputHigh;
    end
  end
  // ***************************************************
  // synthesizer settings
  // ***************************************************
  wire [7:0] s1Ctl = s1Ctl_r[rowIdx_r];
  wire s1On = s1Ctl[`CKG_CTL_EN];
  wire bankSel = s1Ctl[`CKG_CTL_BANK];
  assign synthOnePt = calcPt({s1Ctl[`CKG_CTL_PHI:0], s1P_r[rowIdx_r]},
                             s1Ctl[`CKG_CTL_ODD]);
  assign synthOneQt = calcQt(s1Q_r[rowIdx_r]);
  assign synthOneLoop = s1Ctl[`CKG_CTL_LF_HI:`CKG_CTL_LF_LO];
  assign synthTwoPt = calcPt({twoCtl_r[`CKG_CTL_PHI:0], twoP_r},
                             twoCtl_r[`CKG_CTL_ODD]);
  assign synthTwoQt = calcQt(twoQ_r);
  assign synthTwoLoop = twoCtl_r[`CKG_CTL_LF_HI:`CKG_CTL_LF_LO];
  assign synthThreePt = calcPt({s3Ctl_r[`CKG_CTL_PHI:0], s3P_r},
                               s3Ctl_r[`CKG_CTL_ODD]);
  assign synthThreeQt = calcQt(s3Q_r);
  assign synthThreeLoop = s3Ctl_r[`CKG_CTL_LF_HI:`CKG_CTL_LF_LO];
  // full shutdown only when pin function select is high
  wire pinFnSel = misc_r[3];
  assign fullShutdown = pinFnSel && !shutdownPin;
  assign synthOneRun = s1On && !fullShutdown;
  assign synthTwoRun = twoCtl_r[`CKG_CTL_EN] && !fullShutdown;
  assign synthThreeRun = s3Ctl_r[`CKG_CTL_EN] && !fullShutdown;
  // oscillator codes
  assign loadCapCode = osc_r[7:2];
  assign oscGainCode = osc_r[1:0];
  // pad trims passed straight to the predrivers
  assign dutyTrimABDE = misc_r[5:4];
  assign dutyTrimCX = misc_r[7:6];
  assign driveTrim = drv_r;
  // ***************************************************
  // source select and main dividers
  // ***************************************************
  // selected word per output; bank picks a/b register
  wire [7:0] wordA = bankSel ? divA1_r : divA0_r;
  wire [7:0] wordB = bankSel ? divB1_r : divB0_r;
  wire [31:0] words = {divD_r, divC_r, wordB, wordA};
  // pin enable: high enables outputs, low disables them, whatever the pin function select
  wire pinEnable = shutdownPin;
  wire [3:0] srcLive;
  wire [3:0] divLive;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : gOut
      wire [2:0] src = {srcHi_r[2*g+1 -: 2], words[8*g+7]};
      wire [6:0] ratio = words[8*g+6 -: 7];
      reg tick;
      reg ok;
      // source mux; reserved code gives no clock
      always @*
      begin
        tick = 1'b0;
        ok = 1'b0;
        case (src[2:1])
          2'h0:
          begin
            tick = refTick && !src[0];
            ok = !src[0];
          end
          `CKG_SRC_S1:
          begin
            tick = synthOneTick[src[0]];
            ok = s1On;
          end
          `CKG_SRC_S2:
          begin
            tick = synthTwoTick[src[0]];
            ok = twoCtl_r[`CKG_CTL_EN];
          end
          `CKG_SRC_S3:
          begin
            tick = synthThreeTick[src[0]];
            ok = s3Ctl_r[`CKG_CTL_EN];
          end
          default:
          begin
            tick = 1'b0;
            ok = 1'b0;
          end
        endcase
      end
      // disabled source acts as zero ratio
      // a new nonzero ratio waits for the divider's period end
      ckg_post_div #(.WIDTH(DIV_W)) uDiv
      (
        .clk(clk),
        .sys_rst(sys_rst),
        .ratio(ok && !fullShutdown ? ratio : 7'h00),
        .srcTick(tick),
        .divOut(outMain[g])
      );
      assign srcLive[g] = ok;
      assign divLive[g] = ratio != 7'h00 && ok && pinEnable;
      assign outMainOe_n[g] = !divLive[g];
    end
  endgenerate
  // ***************************************************
  // output e fixed divider
  // ***************************************************
  wire [1:0] eCode = misc_r[1:0];
  wire eLive = eCode != 2'h0 && s1On && pinEnable;
  reg [1:0] eCnt_r;
  reg [1:0] eEnd;
  // 01 -> /4, 10 -> /2, 11 -> /3
  always @*
  begin
    case (eCode)
      2'h1: eEnd = 2'h3;
      2'h2: eEnd = 2'h1;
      2'h3: eEnd = 2'h2;
      default: eEnd = 2'h0;
    endcase
  end
  always @(posedge clk)
  begin
    if (sys_rst || !eLive)
    begin
      eCnt_r <= 2'h0;
      outputE <= 1'b0;
    end
    else if (synthOneTick[0])
    begin
      eCnt_r <= (eCnt_r >= eEnd) ? 2'h0 : eCnt_r + 2'h1;
      // high for the lower half of the count
      outputE <= (eCnt_r + 2'h1 <= eEnd[1:1] + {1'b0, eEnd[0]}) &&
                 (eCnt_r < eEnd);
    end
  end
  assign outputEOe_n = !eLive;
  // ***************************************************
  // buffered reference
  // ***************************************************
  wire refBufEn = misc_r[2] && pinEnable;
  assign refBufOut = refTick && refBufEn;
  assign refBufOe_n = !refBufEn;
  // ***************************************************
  // read path
  // ***************************************************
  always @(posedge clk)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0000_0000;
      case (addr)
        `CKG_A_DIV0: prdata[7:0] <= divA0_r;
        `CKG_A_DIV1: prdata[7:0] <= divA1_r;
        `CKG_B_DIV0: prdata[7:0] <= divB0_r;
        `CKG_B_DIV1: prdata[7:0] <= divB1_r;
        `CKG_C_DIV: prdata[7:0] <= divC_r;
        `CKG_D_DIV: prdata[7:0] <= divD_r;
        `CKG_SRC_HI: prdata[7:0] <= srcHi_r;
        `CKG_MISC: prdata[7:0] <= misc_r;
        `CKG_DRV: prdata[7:0] <= drv_r;
        `CKG_TWO_Q: prdata[7:0] <= twoQ_r;
        `CKG_TWO_P: prdata[7:0] <= twoP_r;
        `CKG_TWO_CTL: prdata[7:0] <= twoCtl_r;
        `CKG_S3_Q: prdata[7:0] <= s3Q_r;
        `CKG_S3_P: prdata[7:0] <= s3P_r;
        `CKG_S3_CTL: prdata[7:0] <= s3Ctl_r;
        `CKG_OSC: prdata[7:0] <= osc_r;
        `CKG_STATUS: prdata[9:0] <= {divLive & srcLive, eLive,
                                     s1On, bankSel, rowIdx_r};
        default:
        begin
          if (s1Hit && s1Sel == 2'h0)
            prdata[7:0] <= s1Q_r[s1Row];
          else if (s1Hit && s1Sel == 2'h1)
            prdata[7:0] <= s1P_r[s1Row];
          else if (s1Hit && s1Sel == 2'h2)
            prdata[7:0] <= s1Ctl_r[s1Row];
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [core/ckg_defs.vh]
// Purpose: constants for the clock generator configuration block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses chosen for this block
//
// Overview of operation
// - 7-bit post divider, ratio 1..127, odd corrected
// - divider zero powers down, output high-z
// - outputs a,b have two banks, bank select
// - output e code: off, /4, /2, /3
// - 3-bit source select per main output
// - buffered reference driven only when enabled
// - pin function select picks shutdown or enable
// - 2-bit duty trim, nominal 01
// - 2-bit drive trim codes for strength
// - synth ratio uses feedback and reference values
// - synth one disable switches off dependents
// - load cap code, zero for external reference
// - nonzero divider writes wait for the running period's end
// - each synth byte takes effect on its write
// - programming port works during shutdown
// - select input change is glitch free
// - three select levels index synth one table
// - blank device: all zero, outputs high-z
`ifndef CKG_DEFS_VH
`define CKG_DEFS_VH
`define CKG_ADDR_W 8
// output divider registers: bit7 src[0], bits6:0 ratio
`define CKG_A_DIV0 8'h00
`define CKG_A_DIV1 8'h04
`define CKG_B_DIV0 8'h08
`define CKG_B_DIV1 8'h0c
`define CKG_C_DIV 8'h10
`define CKG_D_DIV 8'h14
// source high bits: [1:0] a, [3:2] b, [5:4] c, [7:6] d
`define CKG_SRC_HI 8'h18
// duty/enable: [1:0] e div,[2] xbuf oe,[3] pin fn,[5:4] abde duty,
// [7:6] cx duty
`define CKG_MISC 8'h1c
// drive trim: [1:0] ab, [3:2] c, [5:4] de, [7:6] x
`define CKG_DRV 8'h20
// synth two and three: q, p low, ctrl
`define CKG_TWO_Q 8'h24
`define CKG_TWO_P 8'h28
`define CKG_TWO_CTL 8'h2c
`define CKG_S3_Q 8'h30
`define CKG_S3_P 8'h34
`define CKG_S3_CTL 8'h38
// oscillator: [1:0] gain, [7:2] load cap
`define CKG_OSC 8'h3c
// synth one table: row n at base + 16n, q/p/ctl at +0/+4/+8
`define CKG_S1_BASE 8'h40
// status: [2:0] row index, [3] bank, [4] s1 enable, [9:5] out live
`define CKG_STATUS 8'hc0
// ctl byte fields
`define CKG_CTL_PHI 1
`define CKG_CTL_ODD 2
`define CKG_CTL_LF_LO 3
`define CKG_CTL_LF_HI 5
`define CKG_CTL_EN 6
`define CKG_CTL_BANK 7
// source codes
`define CKG_SRC_REF 3'h0
`define CKG_SRC_S1 2'h1
`define CKG_SRC_S2 2'h2
`define CKG_SRC_S3 2'h3
`endif

// [core/ckg_post_div.v]
// Purpose: 7-bit post divider with odd duty correction
// Assumes: source pulse is one clk cycle per source edge
// Notes: zero ratio parks the divider and holds output low
`default_nettype none
module ckg_post_div
#(
  parameter WIDTH = 7
)
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // control
  input wire [WIDTH-1:0] ratio,
  input wire srcTick,
  // output
  output reg divOut
);
  // full-period counter in source ticks
  reg [WIDTH:0] cnt_r;
  reg phase_r;
  // ratio in use; a new nonzero ratio waits for the end of the running
  // period, so a bank swap to a nonzero ratio never cuts a pulse short
  reg [WIDTH-1:0] live_r;
  wire [WIDTH-1:0] useRatio = (live_r == {WIDTH{1'b0}}) ? ratio : live_r;
  wire [WIDTH:0] ratio2 = {useRatio, 1'b0};
  wire wrap = cnt_r >= ratio2 - 1'b1;
  // counts ticks of twice the ratio; high for first ratio ticks
  // gives exact 50 percent even for odd ratios
  always @(posedge clk)
  begin
    if (sys_rst || ratio == {WIDTH{1'b0}})
    begin
      // powered down at once, no waiting
      cnt_r <= {(WIDTH+1){1'b0}};
      phase_r <= 1'b0;
      divOut <= 1'b0;
      live_r <= {WIDTH{1'b0}};
    end
    else if (srcTick)
    begin
      if (wrap)
      begin
        // period boundary: pick up any new ratio
        cnt_r <= {(WIDTH+1){1'b0}};
        live_r <= ratio;
      end
      else
      begin
        cnt_r <= cnt_r + 1'b1;
        live_r <= useRatio;
      end
      phase_r <= (cnt_r + 1'b1 < {1'b0, useRatio}) || wrap;
      divOut <= phase_r;
    end
  end
endmodule
`default_nettype wire

// [tb/ckg_config_props.sv]
// Purpose: concurrent checks on ckg_config ports
// Assumes: one clock, sync active-high reset
// Notes: bound to every ckg_config instance
`default_nettype none
// **********
// checker
// **********
module ckg_config_props (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  // pins
  input wire shutdownPin,
  input wire refTick,
  // outputs
  input wire [3:0] outMainOe_n,
  input wire outputEOe_n,
  input wire refBufOut,
  input wire refBufOe_n,
  input wire [10:0] synthTwoPt,
  input wire [8:0] synthTwoQt,
  input wire synthOneRun,
  input wire fullShutdown
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // a completed write, pready is always high here
  wire wrAcc = psel & penable & pwrite;
  // pin held low for two edges, outputs may be registered
  sequence s_pin_low;
    !shutdownPin ##1 !shutdownPin;
  endsequence
  sequence s_one_off;
    !synthOneRun ##1 !synthOneRun;
  endsequence
  a_qt_byte_write: assert property ($changed(synthTwoQt) |->
    $past(wrAcc && paddr == 12'h024))
    else $error("qt moved without its byte write");
  a_pt_byte_write: assert property ($changed(synthTwoPt) |->
    $past(wrAcc && (paddr == 12'h028 || paddr == 12'h02c)))
    else $error("pt moved without its byte write");
  a_reset_all_off: assert property ($past(sys_rst) |->
    &outMainOe_n && outputEOe_n && refBufOe_n)
    else $error("output driven just after reset");
  a_pin_quiet: assert property (s_pin_low |->
    &outMainOe_n && outputEOe_n)
    else $error("output driven with pin low");
  a_shut_needs_pin: assert property (fullShutdown |->
    !shutdownPin)
    else $error("shutdown with pin high");
  a_refbuf_gate: assert property (refBufOut |->
    refTick && !refBufOe_n)
    else $error("buffered reference not gated");
  a_one_off_e: assert property (s_one_off |-> outputEOe_n)
    else $error("output e live with synth one off");
  a_ratio_floor: assert property (synthTwoQt >= 9'd2 &&
    synthTwoPt >= 11'd6)
    else $error("synth ratio below its offsets");
endmodule
bind ckg_config ckg_config_props u_props (.clk(clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .shutdownPin(shutdownPin),
  .refTick(refTick), .outMainOe_n(outMainOe_n),
  .outputEOe_n(outputEOe_n), .refBufOut(refBufOut),
  .refBufOe_n(refBufOe_n), .synthTwoPt(synthTwoPt),
  .synthTwoQt(synthTwoQt), .synthOneRun(synthOneRun),
  .fullShutdown(fullShutdown));
`default_nettype wire

// [tb/ckg_config_tb.sv]
// Purpose: self-checking bench for ckg_config
// Assumes: every source tick held high, one tick per clk
// Notes: status row index from pins, clk pin 1, data pin 0
`default_nettype none
// **********
// bench
// **********
module ckg_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic sys_rst = 1;
  logic selHi = 0;
  logic shutdownPin = 1;
  logic [1:0] tk = 2'h3;  // ticks every cycle
  wire psel, penable, pwrite, pready, pslverr;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] outMain, outMainOe_n;
  wire outputE, outputEOe_n, refBufOut, refBufOe_n, twoRun, s1Run, s3Run;
  wire [10:0] twoPt, s1Pt, s3Pt;
  wire [8:0] twoQt, s1Qt, s3Qt;
  wire [2:0] twoLoop, s1Loop, s3Loop;
  wire [5:0] cap;
  wire [1:0] gain, dCx, dAbde;
  wire [7:0] drv;
  wire fullShutdown;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  int hi, rs;
  logic [31:0] rdat;
  logic err;
  ckg_host_model host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));
  ckg_config DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .selectInputHigh(selHi),
    .serialClkPin(1'b1), .serialDataPin(1'b0),
    .shutdownPin(shutdownPin), .refTick(tk[0]), .synthOneTick(tk),
    .synthTwoTick(tk), .synthThreeTick(tk), .outMain(outMain),
    .outMainOe_n(outMainOe_n), .outputE(outputE),
    .outputEOe_n(outputEOe_n), .refBufOut(refBufOut),
    .refBufOe_n(refBufOe_n), .synthOnePt(s1Pt), .synthOneQt(s1Qt),
    .synthOneLoop(s1Loop), .synthOneRun(s1Run), .synthTwoPt(twoPt),
    .synthTwoQt(twoQt), .synthTwoLoop(twoLoop), .synthTwoRun(twoRun),
    .synthThreePt(s3Pt), .synthThreeQt(s3Qt), .synthThreeLoop(s3Loop),
    .synthThreeRun(s3Run), .loadCapCode(cap), .oscGainCode(gain),
    .dutyTrimCX(dCx), .dutyTrimABDE(dAbde), .driveTrim(drv),
    .fullShutdown(fullShutdown));
  always #2.5 clk = ~clk;
  // hang guard, run needs about 1100 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // wide enough for the paired counts and error-plus-data checks
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // upper bits kept zero, reserved positions stay low
  task wr(input logic [11:0] a, input logic [7:0] d);
    host.xfer(1, a, {24'h0, d}, rdat, err);
    @(posedge clk);
  endtask
  task rd(input logic [11:0] a);
    host.xfer(0, a, 32'h0, rdat, err);
  endtask
  // count high cycles and rising edges of one output
  task meas(input int s, input int n);
    logic pv, b;
    hi = 0;
    rs = 0;
    repeat (4) @(posedge clk);
    pv = (s == 4) ? outputE : outMain[s];
    repeat (n)
    begin
      @(posedge clk);
      b = (s == 4) ? outputE : outMain[s];
      hi += b;
      rs += (b && !pv);
      pv = b;
    end
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rd(12'h0c0);
    chk(rdat, 32'h2);
    for (int a = 0; a < 'h40; a += 4)
    begin
      rd(a[11:0]);
      chk(rdat, 32'h0);
    end
    rd(12'h0bc);
    chk({err, rdat}, {1'b1, 32'h0});
    chk(outMainOe_n, 4'hf);
    chk(outputEOe_n, 1'b1);
    selHi <= 1;
    rd(12'h0c0);
    chk(rdat, 32'h6);
    selHi <= 0;
    $display("test blank done");
    // synth two starts disabled, bytes land one by one
    wr(12'h024, 8'h05);
    chk({twoQt, twoPt}, {9'd7, 11'd6});
    wr(12'h028, 8'h10);
    chk(twoPt, 11'd38);
    wr(12'h02c, 8'h4d); // loop 001 for pt 551
    chk({twoPt, twoLoop, twoRun}, {11'd551, 3'h1, 1'b1});
    wr(12'h030, 8'h01);
    chk({s3Pt, s3Qt, s3Loop, s3Run}, {11'd6, 9'd3, 3'h0, 1'b0});
    $display("test synth done");
    wr(12'h03c, 8'hb6); // gain 10 for the crystal
    chk({cap, gain}, {6'h2d, 2'h2});
    wr(12'h020, 8'he4);
    chk(drv, 8'he4);
    wr(12'h01c, 8'h90);
    chk({dCx, dAbde}, {2'h2, 2'h1});
    wr(12'h01c, 8'h04);
    chk({refBufOe_n, refBufOut}, 2'b01);
    wr(12'h01c, 8'h00);
    chk(refBufOe_n, 1'b1);
    wr(12'h01c, 8'h08);
    shutdownPin <= 0;
    wr(12'h03c, 8'h11);
    chk(fullShutdown, 1'b1);
    rd(12'h03c);
    chk(rdat, 32'h11);
    shutdownPin <= 1;
    wr(12'h01c, 8'h00);
    chk(fullShutdown, 1'b0);
    $display("test trims done");
    wr(12'h010, 8'h03);
    meas(2, 60);
    chk({hi, rs}, {32'd30, 32'd10});
    wr(12'h010, 8'h7f);
    meas(2, 254);
    chk({hi, rs}, {32'd127, 32'd1});
    wr(12'h010, 8'h00);
    meas(2, 1);
    chk(outMainOe_n[2], 1'b1);
    wr(12'h010, 8'h83);
    meas(2, 1);
    chk(outMainOe_n[2], 1'b1);
    wr(12'h018, 8'h20);
    wr(12'h010, 8'h02);
    meas(2, 60);
    chk({outMainOe_n[2], rs}, {1'b0, 32'd15});
    wr(12'h010, 8'h00); // no divider on a stopped synth
    wr(12'h02c, 8'h0d);
    wr(12'h010, 8'h02);
    meas(2, 1);
    chk(outMainOe_n[2], 1'b1);
    $display("test divider done");
    // row two of the synth one table, synth one still off
    wr(12'h060, 8'h0a);
    wr(12'h064, 8'h20);
    chk({s1Pt, s1Qt, s1Loop}, {11'd70, 9'd12, 3'h0});
    // new ratio into unused bank, then switch
    wr(12'h000, 8'h01);
    wr(12'h004, 8'h02);
    meas(0, 60);
    chk(rs, 32'd30);
    wr(12'h068, 8'h80);
    meas(0, 60);
    chk(rs, 32'd15);
    wr(12'h068, 8'hc0);
    for (int c = 1; c < 4; c++)
    begin
      wr(12'h01c, c[7:0]);
      meas(4, 60);
      chk(rs, (c == 1) ? 15 : (c == 2) ? 30 : 20);
    end
    wr(12'h068, 8'h80);
    meas(4, 1);
    chk({s1Run, outputEOe_n}, 2'b01);
    // bank one still selected: b runs from its second register
    wr(12'h00c, 8'h02);
    meas(1, 60);
    chk(rs, 32'd15);
    wr(12'h014, 8'h04);
    meas(3, 64);
    chk({hi, rs}, {32'd32, 32'd8});
    $display("test banks done");
    wrap_up();
  end
endmodule
`default_nettype wire

// [tb/ckg_host_model.sv]
// Purpose: apb host standing in for the serial controller
// Assumes: transfers called one at a time by the bench
// Notes: bus released only at the edge that samples pready
`default_nettype none
// **********
// host
// **********
module ckg_host_model (
  // clock
  input wire logic clk,
  // request
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [11:0] paddr,
  output var logic [31:0] pwdata,
  // answer
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
  end
  // setup, access until pready, then release
  task xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // released lines must not keep their last value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire
